// file: logic/adrs_top.sv
// Our own choice: the AHB-Lite slave port.
module adrs_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic comp_in,
  output logic mux_enable,
  output logic [2:0] mux_select,
  output logic sample_hold,
  output logic [9:0] dac_code,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [3:0] channel_sel;
  logic start_busy_flag;
  logic converter_clock_stop;
  logic [9:0] result_value;
  logic [adrs_pkg::NUM_EVENTS-1:0] irq_status;
  logic [adrs_pkg::NUM_EVENTS-1:0] irq_mask;
  logic [adrs_pkg::NUM_EVENTS-1:0] events;
  logic [adrs_pkg::NUM_EVENTS-1:0] next_irq_status;

  logic wr_pending;
  logic [17:0] wr_addr;
  logic wr_mapped_hi;
  logic addr_ok;
  logic rd_take;
  logic wr_result;
  logic wr_mode;
  logic wr_start;
  logic wr_clkstop;
  logic wr_status;
  logic wr_mask;
  logic [31:0] read_mux;

  logic chan_valid;
  logic [3:0] chan_offset;
  logic start_req;
  logic abort_req;
  logic sar_busy;
  logic sar_sampling;
  logic sar_done;
  logic [9:0] sar_result;
  logic [9:0] sar_dac;
  logic comp_level;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY

  assign addr_ok = (haddr[31:18] == 14'h0000);
  assign rd_take = hsel && hready && (htrans == adrs_pkg::HTRANS_NONSEQ) && !hwrite;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pending <= 1'b0;
      wr_addr <= 18'h0_0000;
      wr_mapped_hi <= 1'b0;
    end else if (ce && hready) begin
      wr_pending <= hsel && (htrans == adrs_pkg::HTRANS_NONSEQ) && hwrite;
      wr_addr <= haddr[17:0];
      wr_mapped_hi <= addr_ok;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b1;
      hresp <= adrs_pkg::HRESP_OKAY;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= adrs_pkg::HRESP_OKAY;
    end
  end

  // Writes to the result register are decoded only so that they can be dropped
  always_comb begin
    wr_result = 1'b0;
    wr_mode = 1'b0;
    wr_start = 1'b0;
    wr_clkstop = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    if (!(wr_pending && wr_mapped_hi)) begin
      wr_result = 1'b0;
    end else if (wr_addr == adrs_pkg::ADDR_RESULT) begin
      wr_result = 1'b1;
    end else if (wr_addr == adrs_pkg::ADDR_MODE) begin
      wr_mode = 1'b1;
    end else if (wr_addr == adrs_pkg::ADDR_START) begin
      wr_start = 1'b1;
    end else if (wr_addr == adrs_pkg::ADDR_CLKSTOP) begin
      wr_clkstop = 1'b1;
    end else if (wr_addr == adrs_pkg::ADDR_IRQ_STATUS) begin
      wr_status = 1'b1;
    end else if (wr_addr == adrs_pkg::ADDR_IRQ_MASK) begin
      wr_mask = 1'b1;
    end
  end

  always_comb begin
    read_mux = 32'h0000_0000;
    if (!addr_ok) begin
      read_mux = 32'h0000_0000;
    end else if (haddr[17:0] == adrs_pkg::ADDR_RESULT) begin
      // Low six bits always zero; value mid-conversion is the previous one
      read_mux[adrs_pkg::RESULT_MSB_POS:adrs_pkg::RESULT_LSB_POS] = result_value;
    end else if (haddr[17:0] == adrs_pkg::ADDR_MODE) begin
      read_mux[3:0] = channel_sel;
    end else if (haddr[17:0] == adrs_pkg::ADDR_START) begin
      read_mux[adrs_pkg::START_FLAG_POS] = start_busy_flag;
    end else if (haddr[17:0] == adrs_pkg::ADDR_CLKSTOP) begin
      read_mux[adrs_pkg::CLOCK_STOP_POS] = converter_clock_stop;
    end else if (haddr[17:0] == adrs_pkg::ADDR_IRQ_STATUS) begin
      read_mux[adrs_pkg::NUM_EVENTS-1:0] = irq_status;
    end else if (haddr[17:0] == adrs_pkg::ADDR_IRQ_MASK) begin
      read_mux[adrs_pkg::NUM_EVENTS-1:0] = irq_mask;
    end
  end

  // Read data is captured in the address phase so the data phase needs no wait
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && rd_take) begin
      hrdata <= read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_sel <= adrs_pkg::MODE_RESET;
    end else if (ce && wr_mode) begin
      channel_sel <= hwdata[3:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      converter_clock_stop <= adrs_pkg::CLOCK_STOP_RESET;
    end else if (ce && wr_clkstop) begin
      converter_clock_stop <= hwdata[adrs_pkg::CLOCK_STOP_POS];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_mask <= adrs_pkg::EVENTS_RESET;
    end else if (ce && wr_mask) begin
      irq_mask <= hwdata[adrs_pkg::NUM_EVENTS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel decode and conversion control

  assign chan_valid = (channel_sel >= adrs_pkg::CHAN_FIRST) &&
                      (channel_sel <= adrs_pkg::CHAN_LAST);
  assign chan_offset = channel_sel - adrs_pkg::CHAN_FIRST;

  // A start with no usable channel is refused and flagged; one in standby on a usable channel is refused without a flag
  assign start_req = wr_start && hwdata[adrs_pkg::START_FLAG_POS] && !start_busy_flag &&
                     chan_valid && converter_clock_stop;
  assign abort_req = (wr_start && !hwdata[adrs_pkg::START_FLAG_POS] && start_busy_flag &&
                      !sar_done) || (!converter_clock_stop && start_busy_flag);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_busy_flag <= 1'b0;
    end else if (ce) begin
      if (sar_done) begin
        start_busy_flag <= 1'b0;
      end else if (abort_req) begin
        start_busy_flag <= 1'b0;
      end else if (start_req) begin
        start_busy_flag <= 1'b1;
      end
    end
  end

  // Reset to zero for cleaner simulation, though software may not rely on it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_value <= adrs_pkg::RESULT_RESET;
    end else if (ce && sar_done) begin
      result_value <= sar_result;
    end
  end

  adrs_sync u_comp_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .async_in(comp_in),
    .level(comp_level)
  );

  adrs_sar u_sar (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .start(start_req),
    .abort(abort_req),
    .comp_level(comp_level),
    .busy(sar_busy),
    .sampling(sar_sampling),
    .dac_code(sar_dac),
    .done(sar_done),
    .result(sar_result)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mux_enable <= 1'b0;
      mux_select <= 3'h0;
      sample_hold <= 1'b0;
      dac_code <= 10'h000;
    end else if (ce) begin
      mux_enable <= sar_busy && converter_clock_stop;
      mux_select <= chan_offset[2:0];
      sample_hold <= sar_sampling && converter_clock_stop;
      dac_code <= sar_dac;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, write one to clear, set beats clear

  assign events[adrs_pkg::EV_DONE] = sar_done;
  assign events[adrs_pkg::EV_ABORT] = abort_req;
  assign events[adrs_pkg::EV_BAD_CHANNEL] = wr_start && hwdata[adrs_pkg::START_FLAG_POS] &&
                                           !start_busy_flag && !chan_valid;

  always_comb begin
    next_irq_status = irq_status;
    if (wr_status) begin
      next_irq_status = irq_status & ~hwdata[adrs_pkg::NUM_EVENTS-1:0];
    end
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_status <= adrs_pkg::EVENTS_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end

endmodule // adrs_top

// file: common/adrs_pkg.sv
package adrs_pkg;

  // Printed offsets are register indices; the byte address is four times the index
  localparam logic [15:0] IDX_RESULT = 16'hffbc;
  localparam logic [15:0] IDX_MODE = 16'hffbe;
  localparam logic [15:0] IDX_START = 16'hffbf;
  localparam logic [15:0] IDX_CLKSTOP = 16'hfffa;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hffc1;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hffc2;
  localparam logic [17:0] ADDR_RESULT = {IDX_RESULT, 2'b00};
  localparam logic [17:0] ADDR_MODE = {IDX_MODE, 2'b00};
  localparam logic [17:0] ADDR_START = {IDX_START, 2'b00};
  localparam logic [17:0] ADDR_CLKSTOP = {IDX_CLKSTOP, 2'b00};
  localparam logic [17:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [17:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

  // Field positions
  localparam int RESULT_LSB_POS = 6;
  localparam int RESULT_MSB_POS = 15;
  localparam int START_FLAG_POS = 7;
  localparam int CLOCK_STOP_POS = 4;
  localparam int EV_DONE = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_BAD_CHANNEL = 2;
  localparam int NUM_EVENTS = 3;

  // Channel codes
  localparam logic [3:0] CHAN_FIRST = 4'h4;
  localparam logic [3:0] CHAN_LAST = 4'hb;

  // Reset values
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic CLOCK_STOP_RESET = 1'b1;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [NUM_EVENTS-1:0] EVENTS_RESET = 3'h0;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SAMPLE_TIME_NS = 100;
  localparam int SETTLE_TIME_NS = 24;
  localparam int SAMPLE_CYCLES = (SAMPLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESULT_BITS = 10;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [1:0] {
    ADRS_SAR_IDLE,
    ADRS_SAR_SAMPLE,
    ADRS_SAR_SETTLE,
    ADRS_SAR_DONE
  } adrs_sar_state_t;

endpackage

// file: logic/adrs_sync.sv
module adrs_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic async_in,
  output logic level
);

  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else if (ce) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change only counts once the two settled stages agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level <= 1'b0;
    end else if (ce && (stage2 == stage3)) begin
      level <= stage3;
    end
  end

endmodule // adrs_sync

// file: logic/adrs_sar.sv
module adrs_sar (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic start,
  input wire logic abort,
  input wire logic comp_level,
  output logic busy,
  output logic sampling,
  output logic [9:0] dac_code,
  output logic done,
  output logic [9:0] result
);

  adrs_pkg::adrs_sar_state_t state;
  logic [7:0] wait_cnt;
  logic [3:0] bit_idx;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= adrs_pkg::ADRS_SAR_IDLE;
      wait_cnt <= 8'h00;
      bit_idx <= 4'h0;
      dac_code <= 10'h000;
      result <= adrs_pkg::RESULT_RESET;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (abort) begin
        state <= adrs_pkg::ADRS_SAR_IDLE;
        dac_code <= 10'h000;
      end else begin
        case (state)
          adrs_pkg::ADRS_SAR_IDLE: begin
            if (start) begin
              state <= adrs_pkg::ADRS_SAR_SAMPLE;
              wait_cnt <= 8'(adrs_pkg::SAMPLE_CYCLES - 1);
            end
          end
          adrs_pkg::ADRS_SAR_SAMPLE: begin
            if (wait_cnt == 8'h00) begin
              state <= adrs_pkg::ADRS_SAR_SETTLE;
              bit_idx <= 4'(adrs_pkg::RESULT_BITS - 1);
              dac_code <= 10'h200;
              wait_cnt <= 8'(adrs_pkg::SETTLE_CYCLES + 2);
            end else begin
              wait_cnt <= wait_cnt - 8'h01;
            end
          end
          adrs_pkg::ADRS_SAR_SETTLE: begin
            // Wait covers the synchroniser delay as well as the comparator settling
            if (wait_cnt == 8'h00) begin
              if (!comp_level) begin
                dac_code[bit_idx] <= 1'b0;
              end
              if (bit_idx == 4'h0) begin
                state <= adrs_pkg::ADRS_SAR_DONE;
              end else begin
                dac_code[bit_idx - 4'h1] <= 1'b1;
                bit_idx <= bit_idx - 4'h1;
                wait_cnt <= 8'(adrs_pkg::SETTLE_CYCLES + 2);
              end
            end else begin
              wait_cnt <= wait_cnt - 8'h01;
            end
          end
          adrs_pkg::ADRS_SAR_DONE: begin
            result <= dac_code;
            done <= 1'b1;
            state <= adrs_pkg::ADRS_SAR_IDLE;
          end
          default: state <= adrs_pkg::ADRS_SAR_IDLE;
        endcase
      end
    end
  end

  assign busy = (state != adrs_pkg::ADRS_SAR_IDLE);
  assign sampling = (state == adrs_pkg::ADRS_SAR_SAMPLE);

endmodule // adrs_sar

// file: bench/adrs_monitor.sv
module adrs_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic mux_enable,
  input wire logic [2:0] mux_select,
  input wire logic sample_hold,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic dp_wr;
  logic [31:0] dp_a;
  logic [3:0] mode;
  logic run;
  wire logic tk = ce && hsel && hready && htrans == adrs_pkg::HTRANS_NONSEQ;
  wire logic w_st = dp_wr && dp_a == 32'(adrs_pkg::ADDR_START);
  wire logic w_ck = dp_wr && dp_a == 32'(adrs_pkg::ADDR_CLKSTOP);
  wire logic w_mk = dp_wr && dp_a == 32'(adrs_pkg::ADDR_IRQ_MASK);
  wire logic ok = mode >= adrs_pkg::CHAN_FIRST && mode <= adrs_pkg::CHAN_LAST;
  wire logic [3:0] sel = mode - adrs_pkg::CHAN_FIRST;
  ////////////////////////////////////////
  // Write data arrives one cycle after the taken address phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dp_wr <= 1'b0;
      dp_a <= 32'h0000_0000;
    end else if (ce) begin
      dp_wr <= tk && hwrite;
      dp_a <= haddr;
    end
  end
  // Shadow of what software last wrote, so decode can be judged
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode <= adrs_pkg::MODE_RESET;
      run <= adrs_pkg::CLOCK_STOP_RESET;
    end else begin
      if (dp_wr && dp_a == 32'(adrs_pkg::ADDR_MODE)) begin
        mode <= hwdata[3:0];
      end
      if (w_ck) begin
        run <= hwdata[adrs_pkg::CLOCK_STOP_POS];
      end
    end
  end
  ////////////////////////////////////////
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_bus_okay:
    assert property (hreadyout && hresp == adrs_pkg::HRESP_OKAY) else $error("bus stall");
  a_result_pad:
    assert property (tk && !hwrite && haddr == 32'(adrs_pkg::ADDR_RESULT)
      |=> hrdata[5:0] == 6'h00 && hrdata[31:16] == 16'h0000) else $error("pad bits");
  a_chan_decode:
    assert property (mux_enable |-> ok && mux_select == sel[2:0]) else $error("mux select");
  a_sample_in_run:
    assert property (sample_hold |-> mux_enable) else $error("stray sample");
  a_start_runs:
    assert property (w_st && hwdata[7] && !mux_enable && ok && run |-> ##[1:4] mux_enable)
      else $error("no start");
  a_start_samples:
    assert property (w_st && hwdata[7] && !mux_enable && ok && run |-> ##[1:4] sample_hold)
      else $error("no sample phase");
  a_abort_stops:
    assert property (w_st && !hwdata[7] && mux_enable |-> ##[1:4] !mux_enable)
      else $error("no abort");
  a_standby_stops:
    assert property (w_ck && !hwdata[adrs_pkg::CLOCK_STOP_POS] |-> ##[1:4] !mux_enable)
      else $error("no standby");
  a_standby_idle:
    assert property (!run && !mux_enable |=> !mux_enable) else $error("run in standby");
  a_irq_masked:
    assert property (w_mk && hwdata[2:0] == 3'h0 |-> ##[1:3] !irq) else $error("irq mask");
  c_done: cover property ($fell(mux_enable) && !w_st && !w_ck);
  c_abort: cover property (w_st && !hwdata[7] && mux_enable);
  c_irq: cover property ($rose(irq));
endmodule // adrs_monitor

bind adrs_top adrs_monitor adrs_monitor_i (
  .clk, .nrst, .ce, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .mux_enable, .mux_select, .sample_hold, .irq
);

// file: bench/adrs_comparator.sv
module adrs_comparator (
  input wire logic clk,
  input wire logic slow,
  input wire logic [9:0] level,
  input wire logic mux_enable,
  input wire logic [2:0] mux_select,
  input wire logic [9:0] dac_code,
  output logic comp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fast;
  logic late;
  logic flip;
  // Each input sits at a different level so a wrong channel shows
  assign fast = (level ^ {7'h00, mux_select}) >= dac_code;
  always @(posedge clk) begin
    late <= fast;
    flip <= (flip === 1'b0);
  end
  // No input connected: output wanders, never a steady guessable level
  assign comp_in = !mux_enable ? flip : (slow ? late : fast);
endmodule // adrs_comparator

// file: bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_RES = 32'(adrs_pkg::ADDR_RESULT);
  localparam logic [31:0] A_MOD = 32'(adrs_pkg::ADDR_MODE);
  localparam logic [31:0] A_ST = 32'(adrs_pkg::ADDR_START);
  localparam logic [31:0] A_CK = 32'(adrs_pkg::ADDR_CLKSTOP);
  localparam logic [31:0] A_IS = 32'(adrs_pkg::ADDR_IRQ_STATUS);
  localparam logic [31:0] A_IM = 32'(adrs_pkg::ADDR_IRQ_MASK);
  localparam logic [31:0] GO = 32'h0000_0080;
  localparam logic [31:0] NIL = 32'h0000_0000;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic slow = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = NIL;
  logic [31:0] hwdata = NIL;
  logic [9:0] level = 10'h000;
  logic [31:0] rv;
  logic [31:0] last;
  wire logic [31:0] hrdata;
  wire logic [9:0] dac_code;
  wire logic [2:0] mux_select;
  wire logic hreadyout, hresp, comp_in, mux_enable, sample_hold, irq;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  adrs_top adrs_top_i (
    .clk, .nrst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .comp_in, .mux_enable, .mux_select,
    .sample_hold, .dac_code, .irq
  );
  adrs_comparator adrs_comparator_i (
    .clk, .slow, .level, .mux_enable, .mux_select, .dac_code, .comp_in
  );
  ////////////////////////////////////////
  task automatic test_done();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= adrs_pkg::HTRANS_NONSEQ;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    xfer(a, 1'b0, NIL);
    chk(rv, e);
  endtask
  task automatic conv(input logic [3:0] c);
    wr(A_MOD, {28'h000_0000, c});
    wr(A_ST, GO);
    rc(A_ST, GO);
    do xfer(A_ST, 1'b0, NIL); while (rv[7] === 1'b1);
    last = {16'h0000, level ^ 10'(c - 4'h4), 6'h00};
    rc(A_RES, last);
  endtask
  ////////////////////////////////////////
  // Bounded run: a stuck poll loop ends here as a failure
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rc(A_CK, 32'h0000_0010);
    rc(A_MOD, NIL);
    rc(A_IM, NIL);
    wr(A_IM, 32'h0000_0007);
    for (int c = 4; c < 12; c++) begin
      level <= 10'(c * 115);
      conv(4'(c));
    end
    slow <= 1'b1;
    conv(4'h7);
    slow <= 1'b0;
    chk(irq, 1'b1);
    wr(A_IS, 32'h0000_0007);
    rc(A_IS, NIL);
    chk(irq, 1'b0);
    level <= 10'h3ff;
    wr(A_RES, 32'hffff_ffff);
    repeat (150) @(posedge clk);
    rc(A_RES, last);
    wr(A_IM, NIL);
    wr(A_ST, GO);
    wr(A_ST, GO);
    // Frozen for longer than a whole conversion, so the flag must still read busy
    ce <= 1'b0;
    repeat (200) @(posedge clk);
    ce <= 1'b1;
    rc(A_ST, GO);
    wr(A_ST, NIL);
    rc(A_ST, NIL);
    rc(A_IS, 32'h0000_0002);
    chk(irq, 1'b0);
    wr(A_IM, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr(A_IS, 32'h0000_0007);
    for (int c = 0; c < 16; c++) begin
      if (c < 4 || c > 11) begin
        wr(A_MOD, 32'(c));
        wr(A_ST, GO);
        rc(A_ST, NIL);
        rc(A_IS, 32'h0000_0004);
        wr(A_IS, 32'h0000_0004);
      end
    end
    wr(A_MOD, 32'h0000_0005);
    wr(A_CK, NIL);
    wr(A_ST, GO);
    rc(A_ST, NIL);
    wr(A_CK, 32'h0000_0010);
    wr(A_ST, GO);
    repeat (10) @(posedge clk);
    wr(A_CK, NIL);
    rc(A_ST, NIL);
    rc(A_IS, 32'h0000_0002);
    wr(A_CK, 32'h0000_0010);
    rc(32'h0003_ff10, NIL);
    conv(4'h4);
    test_done();
  end
endmodule // tb
